// File: rbd_pkg.sv
// Package: constants and types for the reset and boot-download sequencer
package rbd_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned BUSY_ASSERT_NS  = 50;
  localparam int unsigned BUSY_MAX_US     = 1055;
  localparam int unsigned ERASE_EXTRA_US  = 500;
  localparam int unsigned RECOVER_NS      = 660;
  // Longest times round down; the assert bound is met combinationally
  localparam int unsigned BUSY_MAX_CYC    = BUSY_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ERASE_EXTRA_CYC = ERASE_EXTRA_US * (CLK_HZ / 1_000_000);
  // Least time rounds up
  localparam int unsigned RECOVER_CYC     =
    (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 17;
  localparam int unsigned ADDR_W          = 10;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned BOOT_WORDS      = 1024;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 17'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE    = 17'h00001;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 10'h3FF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    RBD_RESET    = 2'b00,
    RBD_DOWNLOAD = 2'b01,
    RBD_SETTLE   = 2'b10,
    RBD_READY    = 2'b11
  } rbd_state_t;
endpackage

// File: rbd_boot_ram.sv
// Boot RAM: internal code store filled by the download engine
`timescale 1ns/1ps
module rbd_boot_ram (
  input  wire logic                      clock_i,
  input  wire logic                      we_i,
  input  wire logic [rbd_pkg::ADDR_W-1:0] waddr_i,
  input  wire logic [rbd_pkg::DATA_W-1:0] wdata_i,
  input  wire logic [rbd_pkg::ADDR_W-1:0] raddr_i,
  output logic      [rbd_pkg::DATA_W-1:0] rdata_o
);
  import rbd_pkg::*;

  logic [DATA_W-1:0] mem [0:BOOT_WORDS-1];

  // No reset: contents are always rewritten by the download
  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // rbd_boot_ram

// File: rbd_sequencer.sv
// Reset, boot-download and first-access sequencer
`timescale 1ns/1ps
// Summary of operation
// - Held in reset while reset input low; download starts on release.
// - Host reads and writes are ignored during the download.
// - Busy low at once on reset; high within 1055 us of release.
// - Erase in progress at reset may add up to 500 us to busy.
// - Download-running flag is 1 during download, 0 exactly when busy high.
// - First read held on busy sees valid boot data by busy negation.
// - Deep sleep exit by toggling deep_sleep_toggle_i; data valid 660 ns later.
module rbd_sequencer (
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire logic                      hard_reset_input_n_i,
  input  wire logic                      erase_active_i,
  input  wire logic                      deep_sleep_toggle_i,
  output logic      [rbd_pkg::ADDR_W-1:0] flash_addr_o,
  input  wire logic [rbd_pkg::DATA_W-1:0] flash_data_i,
  input  wire logic                      host_rd_i,
  input  wire logic                      host_wr_i,
  input  wire logic [rbd_pkg::ADDR_W-1:0] host_addr_i,
  input  wire logic [rbd_pkg::DATA_W-1:0] host_wdata_i,
  output logic      [rbd_pkg::DATA_W-1:0] host_rdata_o,
  output logic                           host_ack_o,
  output logic                           busy_n_o,
  output logic                           download_running_flag_o
);
  import rbd_pkg::*;

  rbd_state_t        state_reg, state_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic              wr_pend_reg, wr_pend_next;
  logic              sleep_reg, sleep_next;
  logic              erase_reg, erase_next;
  logic              ram_we;
  logic [ADDR_W-1:0] ram_waddr;
  logic [DATA_W-1:0] ram_wdata;
  logic [ADDR_W-1:0] ram_raddr;
  logic [DATA_W-1:0] ram_rdata;
  logic              rd_pend_reg, rd_pend_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic              ack_reg, ack_next;
  logic              in_reset;
  logic              ready;
  logic              settle_exit;
  logic              host_open;
  logic              host_we;

  // Pin reset acts at once so busy drops in the same cycle
  assign in_reset = rst_i | ~hard_reset_input_n_i;
  assign ready    = (state_reg == RBD_READY);

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    addr_next    = addr_reg;
    sleep_next   = deep_sleep_toggle_i;
    erase_next   = erase_reg;
    ram_we       = 1'b0;
    ram_waddr    = addr_reg;
    ram_wdata    = flash_data_i;
    wr_pend_next = 1'b0;
    settle_exit  = 1'b0;
    if (in_reset) begin
      state_next   = RBD_RESET;
      cnt_next     = CNT_ZERO;
      addr_next    = ADDR_ZERO;
      // Latch erase state so the extra time is budgeted
      erase_next   = erase_reg | erase_active_i;
    end else begin
      case (state_reg)
        RBD_RESET: begin
          state_next = RBD_DOWNLOAD;
          addr_next  = ADDR_ZERO;
          cnt_next   = CNT_ZERO;
        end
        RBD_DOWNLOAD: begin
          // Flash data arrives one cycle after the address
          wr_pend_next = 1'b1;
          ram_we       = wr_pend_reg;
          ram_waddr    = addr_reg - 10'h001;
          if (wr_pend_reg && addr_reg == ADDR_ZERO) begin
            state_next = RBD_SETTLE;
            ram_waddr  = ADDR_LAST;
            cnt_next   = CNT_ZERO;
          end else begin
            addr_next = addr_reg + 10'h001;
          end
        end
        RBD_SETTLE: begin
          // Two cycles at least: the RAM read port must see the last word
          // Erase recovery stretches busy, bounded within the limit
          settle_exit = (cnt_reg != CNT_ZERO) &&
                        (!erase_reg ||
                         cnt_reg >= CNT_W'(ERASE_EXTRA_CYC / 2));
          if (settle_exit) begin
            state_next = RBD_READY;
            erase_next = 1'b0;
            // A stale settle count would lock the host out after busy
            cnt_next   = CNT_ZERO;
          end else begin
            cnt_next = cnt_reg + CNT_ONE;
          end
        end
        RBD_READY: begin
          // Deep-sleep exit: block accesses for the recovery time
          if (sleep_reg != deep_sleep_toggle_i) begin
            cnt_next = CNT_W'(RECOVER_CYC);
          end else if (cnt_reg != CNT_ZERO) begin
            cnt_next = cnt_reg - CNT_ONE;
          end
        end
        default: state_next = RBD_RESET;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg   <= RBD_RESET;
      cnt_reg     <= CNT_ZERO;
      addr_reg    <= ADDR_ZERO;
      wr_pend_reg <= 1'b0;
      sleep_reg   <= 1'b0;
      erase_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      addr_reg    <= addr_next;
      wr_pend_reg <= wr_pend_next;
      sleep_reg   <= sleep_next;
      erase_reg   <= erase_next;
    end
  end

  // The 1024-word download takes 1025 cycles, far under the busy maximum
  assign flash_addr_o = addr_reg;
  // Busy is combinational so it falls in the reset cycle itself
  assign busy_n_o = ~in_reset & ready;
  assign download_running_flag_o = ~busy_n_o;

  // Host port: data valid when ack pulses; a read stalled on busy is
  // answered in the very cycle busy negates
  assign ram_raddr = host_addr_i;
  // No answer at all until ready and recovered
  assign host_open = busy_n_o & (cnt_reg == CNT_ZERO) & ~ack_reg;

  always_comb begin
    rd_pend_next = 1'b0;
    rdata_next   = rdata_reg;
    ack_next     = 1'b0;
    host_we      = 1'b0;
    if (settle_exit && host_rd_i) begin
      // RAM port already holds the stalled address, so data rises with busy
      rdata_next = ram_rdata;
      ack_next   = 1'b1;
    end else if (host_open) begin
      if (rd_pend_reg) begin
        rdata_next = ram_rdata;
        ack_next   = 1'b1;
      end else if (host_rd_i) begin
        rd_pend_next = 1'b1;
      end else if (host_wr_i) begin
        host_we  = 1'b1;
        ack_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (in_reset) begin
      rd_pend_reg <= 1'b0;
      rdata_reg   <= DATA_ZERO;
      ack_reg     <= 1'b0;
    end else begin
      rd_pend_reg <= rd_pend_next;
      rdata_reg   <= rdata_next;
      ack_reg     <= ack_next;
    end
  end

  assign host_rdata_o = rdata_reg;
  assign host_ack_o   = ack_reg;

  rbd_boot_ram u_ram (
    .clock_i (clock_i),
    .we_i    (ram_we | host_we),
    .waddr_i (ram_we ? ram_waddr : host_addr_i),
    .wdata_i (ram_we ? ram_wdata : host_wdata_i),
    .raddr_i (ram_raddr),
    .rdata_o (ram_rdata)
  );
endmodule // rbd_sequencer

// File: rbd_seq_sva.sv
// Checker: timing relations at the sequencer ports
`timescale 1ns/1ps
module rbd_seq_sva (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic hard_reset_input_n_i,
  input wire logic deep_sleep_toggle_i,
  input wire logic host_rd_i,
  input wire logic host_ack_o,
  input wire logic busy_n_o,
  input wire logic download_running_flag_o
);
  import rbd_pkg::*;
  localparam int BUSY_LIM = BUSY_MAX_CYC + ERASE_EXTRA_CYC;
  int busy_cnt;
  // Counts only while both resets are gone, so a long reset is not blamed
  always_ff @(posedge clock_i)
    busy_cnt <= (rst_i || !hard_reset_input_n_i || busy_n_o) ? 0
                : busy_cnt + 1;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_pin_rst; !hard_reset_input_n_i; endsequence
  sequence s_held_rd; !busy_n_o && host_rd_i ##1 busy_n_o; endsequence
  a_flag_busy_inv: assert property (download_running_flag_o == !busy_n_o)
    else $error("flag and busy disagree");
  a_busy_on_pin: assert property (s_pin_rst |-> !busy_n_o)
    else $error("busy not low in pin reset");
  a_stay_reset: assert property (s_pin_rst |=> !host_ack_o)
    else $error("answer during pin reset");
  a_no_ack_busy: assert property (host_ack_o |-> busy_n_o)
    else $error("answer while busy");
  a_early_ack: assert property
    (host_ack_o && !$past(busy_n_o) |-> $past(host_rd_i))
    else $error("answer at busy negation without a held read");
  a_busy_bound: assert property (busy_cnt <= BUSY_LIM)
    else $error("busy too long");
  a_ack_pulse: assert property (host_ack_o |=> !host_ack_o)
    else $error("answer longer than one cycle");
  a_first_read: assert property (s_held_rd |-> host_ack_o)
    else $error("stalled read not answered at busy negation");
  a_sleep_block: assert property ($changed(deep_sleep_toggle_i) && busy_n_o
    |-> ##3 (!host_ack_o) [*8]) else $error("answer during recovery");
endmodule // rbd_seq_sva

// File: rbd_flash_model.sv
// Flash array stand-in: a fixed word pattern per address
`timescale 1ns/1ps
module rbd_flash_model (
  input  wire logic                      clock_i,
  input  wire logic [rbd_pkg::ADDR_W-1:0] addr_i,
  output logic      [rbd_pkg::DATA_W-1:0] data_o
);
  import rbd_pkg::*;
  // Registered, so data lags the address by one cycle
  always_ff @(posedge clock_i) data_o <= {~addr_i[5:0], addr_i};
endmodule // rbd_flash_model

// File: rbd_sequencer_tb_top.sv
// Testbench: reset, download, first access, traffic, sleep exit
`timescale 1ns/1ps
module rbd_sequencer_tb_top;
  import rbd_pkg::*;
  logic clock_i = 0, rst_i = 1, hard_reset_input_n_i = 1, erase_active_i = 0;
  logic deep_sleep_toggle_i = 0, host_rd_i = 0, host_wr_i = 0;
  logic [ADDR_W-1:0] host_addr_i = ADDR_ZERO, flash_addr_o;
  logic [DATA_W-1:0] host_wdata_i = DATA_ZERO, flash_data_i, host_rdata_o;
  logic [DATA_W-1:0] seen, d;
  logic host_ack_o, busy_n_o, download_running_flag_o;
  int errors = 0, samples_checked = 0, cyc = 0, n, a, k;
  int seed = 32'h2BA7B3A3;
  always #10 clock_i = ~clock_i;
  rbd_sequencer dut (.*);
  rbd_flash_model u_flash (.clock_i, .addr_i(flash_addr_o),
                           .data_o(flash_data_i));
  function automatic logic [DATA_W-1:0] fdat(input int x);
    return {~x[5:0], x[ADDR_W-1:0]};
  endfunction
  task automatic check(string nm, logic [DATA_W-1:0] s, e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task summarize;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Request held until answered; waiting out busy is the stall method
  task automatic op(input logic w, input int ad,
                    input logic [DATA_W-1:0] wd);
    @(negedge clock_i);
    {host_wr_i, host_rd_i} = {w, !w};
    host_addr_i = ad[ADDR_W-1:0];
    host_wdata_i = wd;
    for (n = 0; host_ack_o !== 1'b1 && n < 60000; n++) @(posedge clock_i) #1;
    seen = host_rdata_o;
    @(negedge clock_i);
    {host_wr_i, host_rd_i} = 2'b00;
  endtask
  always @(posedge clock_i) if (++cyc == 40000) begin
    errors++;
    summarize;
  end
  initial begin
    repeat (16) @(negedge clock_i);
    rst_i = 0;
    a = $random(seed) & 32'h3FF;
    op(0, a, DATA_ZERO);
    check("stall_rd", seen, fdat(a));
    check("stall_cyc", n <= BUSY_MAX_CYC, 1);
    check("flag_low", download_running_flag_o, 0);
    $display("test first_access done");
    for (k = 0; k < 26; k++) begin
      a = (k < 2) ? k * 1023 : $random(seed) & 32'h3FF;
      d = DATA_W'($random(seed));
      op(1, a, d);
      op(0, a, DATA_ZERO);
      check("rd_back", seen, d);
    end
    $display("test traffic done");
    @(negedge clock_i);
    {hard_reset_input_n_i, erase_active_i} = 2'b01;
    #1 check("busy_pin", busy_n_o, 0);
    check("flag_pin", download_running_flag_o, 1);
    repeat (3) @(negedge clock_i);
    {hard_reset_input_n_i, erase_active_i} = 2'b10;
    // Flag polling is the host's gate here
    for (n = 0; download_running_flag_o !== 1'b0 && n < 60000; n++)
      @(posedge clock_i) #1;
    check("erase_ext", n >= 12500 && n <= BUSY_LIM(), 1);
    op(0, 1023, DATA_ZERO);
    check("reload", seen, fdat(1023));
    check("reload_wait", n <= 2, 1);
    $display("test erase_reset done");
    for (k = 0; k < 2; k++) begin
      @(negedge clock_i);
      deep_sleep_toggle_i = !deep_sleep_toggle_i;
      op(0, k + 1, DATA_ZERO);
      check("sleep_rd", seen, fdat(k + 1));
      check("sleep_wait", n >= RECOVER_CYC - 1, 1);
    end
    $display("test sleep_exit done");
    summarize;
  end
  function automatic int BUSY_LIM();
    return BUSY_MAX_CYC + ERASE_EXTRA_CYC;
  endfunction
endmodule // rbd_sequencer_tb_top
bind rbd_sequencer rbd_seq_sva u_sva (.*);
